// ---- rtl/ptpl_top.v ----
// process run timer and keypad parameter lock of a motor starter
// keypad signals are same-clock pulses; start/stop/power/fault are pins
`include "ptpl_defines.vh"

// Behaviours
module ptpl_top #(
    parameter SEC_CYC   = `PTPL_SEC_NS / `PTPL_CLK_NS,
    parameter FLASH_CYC = `PTPL_FLASH_MS * 1000000 / `PTPL_CLK_NS
) (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_key_any,
    input  wire        i_key_arrow,
    input  wire        i_key_enter,
    input  wire        i_lock_open,
    input  wire [13:0] i_entry_value,
    input  wire [1:0]  i_param_sel,
    input  wire        i_factory_restore,
    input  wire        i_two_wire,
    input  wire        i_sched_mode,
    input  wire        i_start,
    input  wire        i_stop,
    input  wire        i_power_ok,
    input  wire        i_fault,
    output reg         o_motor_run,
    output reg  [13:0] o_run_timer,
    output reg  [1:0]  o_timer_mode,
    output reg  [13:0] o_timer_preset,
    output reg         o_lock_enabled,
    output reg         o_unlocked,
    output reg  [2:0]  o_disp_mode,
    output reg  [13:0] o_disp_value,
    output reg         o_param_accept
);
    // counts as integers, cut on purpose to the counter widths
    localparam integer UNLOCK_I   = `PTPL_UNLOCK_MIN * `PTPL_MIN_SEC;
    localparam integer MIN_I      = `PTPL_MIN_SEC - 1;
    localparam integer FLASH_I    = FLASH_CYC - 1;
    localparam [8:0]   UNLOCK_SEC = UNLOCK_I[8:0];
    localparam [5:0]   MIN_LAST   = MIN_I[5:0];
    localparam [25:0]  FLASH_LD   = FLASH_I[25:0];

    localparam [2:0] L_IDLE  = 3'b001;
    localparam [2:0] L_ENC   = 3'b010;
    localparam [2:0] L_ENTRY = 3'b100;

    localparam [3:0] T_IDLE = 4'b0001;
    localparam [3:0] T_RUN  = 4'b0010;
    localparam [3:0] T_SUSP = 4'b0100;
    localparam [3:0] T_DONE = 4'b1000;

    // stored code shown in hidden form, zero maps to 3552
    function [13:0] f_hide;
        input [13:0] code;
        reg   [14:0] s;
        begin
            s = {1'b0, code} + `PTPL_HIDE_OFFSET;
            if (s >= `PTPL_DEC_MOD) begin
                s = s - `PTPL_DEC_MOD;
            end
            f_hide = s[13:0];
        end
    endfunction

    function f_in_range;
        input [13:0] v;
        input [13:0] lo;
        input [13:0] hi;
        begin
            f_in_range = (v >= lo) && (v <= hi);
        end
    endfunction

    wire sec_tick;

    ptpl_tick #(
        .CYC (SEC_CYC)
    ) u_tick (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .o_tick  (sec_tick)
    );

    // pin synchroniser: a change counts once stages two and three agree
    reg [3:0] s1_q;
    reg [3:0] s2_q;
    reg [3:0] s3_q;
    reg [3:0] pin_q;
    reg       start_prev_q;
    wire [3:0] pin_agree = ~(s2_q ^ s3_q);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_q         <= 4'h0;
            s2_q         <= 4'h0;
            s3_q         <= 4'h0;
            pin_q        <= 4'h0;
            start_prev_q <= 1'b0;
        end else begin
            s1_q         <= {i_fault, i_power_ok, i_stop, i_start};
            s2_q         <= s1_q;
            s3_q         <= s2_q;
            pin_q        <= (s2_q & pin_agree) | (pin_q & ~pin_agree);
            start_prev_q <= pin_q[`PTPL_PIN_START];
        end
    end

    wire start_lvl  = pin_q[`PTPL_PIN_START];
    wire start_edge = start_lvl & ~start_prev_q;
    wire supply_ok  = pin_q[`PTPL_PIN_PWR] & ~pin_q[`PTPL_PIN_FAULT];
    // two-wire: run level is the command, dropping it is a stop
    wire start_cmd  = (i_two_wire ? start_lvl : start_edge) & supply_ok;
    wire stop_cmd   = i_two_wire ? ~start_lvl : pin_q[`PTPL_PIN_STOP];
    wire halt       = stop_cmd | ~supply_ok;

    // ---------------- parameter lock ----------------
    reg  [2:0]  lstate_q;
    reg  [13:0] code_q;
    reg  [8:0]  unl_sec_q;
    reg  [25:0] flash_q;
    reg         wr_mode;
    reg         wr_preset;

    wire allowed    = ~o_lock_enabled | o_unlocked;
    wire code_valid = f_in_range(i_entry_value, `PTPL_CODE_MIN, `PTPL_CODE_MAX);
    wire flashing   = (o_disp_mode == `PTPL_DISP_END) || (o_disp_mode == `PTPL_DISP_PASS) ||
                      (o_disp_mode == `PTPL_DISP_ERR);
    wire param_enter = i_key_enter & (lstate_q != L_ENTRY) & (i_param_sel != `PTPL_SEL_OTHER);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            lstate_q       <= L_IDLE;
            code_q         <= `PTPL_CODE_RST;
            o_lock_enabled <= 1'b0;
            o_unlocked     <= 1'b0;
            unl_sec_q      <= 9'h000;
            flash_q        <= 26'h0000000;
            o_disp_mode    <= `PTPL_DISP_PARAM;
            o_disp_value   <= 14'h0000;
        end else begin
            // unlock window floats with every key press
            if (o_unlocked) begin
                if (i_key_any) begin
                    unl_sec_q <= UNLOCK_SEC;
                end else if (sec_tick) begin
                    if (unl_sec_q == 9'h001) begin
                        o_unlocked <= 1'b0;
                    end
                    unl_sec_q <= unl_sec_q - 9'h001;
                end
            end

            // flash stands its count, then back to the parameter number
            if (flashing) begin
                if (flash_q == 26'h0000000) begin
                    o_disp_mode <= `PTPL_DISP_PARAM;
                end else begin
                    flash_q <= flash_q - 26'h0000001;
                end
            end
            case (lstate_q)
                L_IDLE: begin
                    if (i_lock_open) begin
                        lstate_q     <= L_ENC;
                        o_disp_mode  <= `PTPL_DISP_VALUE;
                        o_disp_value <= f_hide(code_q);
                    end else if (param_enter && !allowed) begin
                        o_disp_mode <= `PTPL_DISP_ERR;
                        flash_q     <= FLASH_LD;
                    end else if (param_enter && !(wr_mode || wr_preset)) begin
                        o_disp_mode <= `PTPL_DISP_ERR;
                        flash_q     <= FLASH_LD;
                    end
                end
                L_ENC: begin
                    if (i_key_arrow) begin
                        lstate_q     <= L_ENTRY;
                        o_disp_value <= 14'h0000;
                    end else if (i_key_enter) begin
                        lstate_q    <= L_IDLE;
                        o_disp_mode <= `PTPL_DISP_PARAM;
                    end
                end
                L_ENTRY: begin
                    o_disp_value <= i_entry_value;
                    if (i_key_enter) begin
                        lstate_q <= L_IDLE;
                        flash_q  <= FLASH_LD;
                        if (!code_valid) begin
                            o_disp_mode <= `PTPL_DISP_ERR;
                        end else if (!allowed) begin
                            if (i_entry_value == code_q) begin
                                o_disp_mode <= `PTPL_DISP_PASS;
                                o_unlocked  <= 1'b1;
                                unl_sec_q   <= UNLOCK_SEC;
                            end else begin
                                o_disp_mode <= `PTPL_DISP_ERR;
                            end
                        end else begin
                            code_q         <= i_entry_value;
                            o_lock_enabled <= (i_entry_value != 14'h0000);
                            o_unlocked     <= 1'b0;
                            o_disp_mode    <= `PTPL_DISP_END;
                        end
                    end
                end
                default: begin
                    lstate_q <= L_IDLE;
                end
            endcase
        end
    end

    // ---------------- timer settings ----------------
    always @* begin
        wr_mode   = 1'b0;
        wr_preset = 1'b0;
        if (param_enter && allowed) begin
            if (i_param_sel == `PTPL_SEL_TMODE) begin
                wr_mode = (i_entry_value <= {12'h000, `PTPL_MODE_PERMIT});
            end
            if (i_param_sel == `PTPL_SEL_PRESET) begin
                wr_preset = f_in_range(i_entry_value, `PTPL_PRESET_MIN,
                                       `PTPL_PRESET_MAX);
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_timer_mode   <= `PTPL_MODE_RST;
            o_timer_preset <= `PTPL_PRESET_RST;
            o_param_accept <= 1'b0;
        end else begin
            o_param_accept <= (wr_mode | wr_preset) & ~i_factory_restore;
            // restore wins over a same-cycle write and leaves the lock code
            if (i_factory_restore) begin
                o_timer_mode   <= `PTPL_MODE_RST;
                o_timer_preset <= `PTPL_PRESET_RST;
            end else begin
                if (wr_mode) begin
                    o_timer_mode <= i_entry_value[1:0];
                end
                if (wr_preset) begin
                    o_timer_preset <= i_entry_value;
                end
            end
        end
    end

    // ---------------- run timer and motor ----------------
    reg [3:0] tstate_q;
    reg [5:0] sec_cnt_q;
    wire batch = (o_timer_mode == `PTPL_MODE_BATCH);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            tstate_q    <= T_IDLE;
            sec_cnt_q   <= 6'h00;
            o_run_timer <= `PTPL_PRESET_RST;
            o_motor_run <= 1'b0;
        end else if (!batch) begin
            // plain starter: follows start and stop, timer parked at preset
            tstate_q    <= T_IDLE;
            sec_cnt_q   <= 6'h00;
            o_run_timer <= o_timer_preset;
            if (halt) begin
                o_motor_run <= 1'b0;
            end else if (start_cmd) begin
                o_motor_run <= 1'b1;
            end
        end else begin
            case (tstate_q)
                T_IDLE: begin
                    o_motor_run <= 1'b0;
                    o_run_timer <= o_timer_preset;
                    sec_cnt_q   <= 6'h00;
                    if (start_cmd && !halt) begin
                        tstate_q    <= T_RUN;
                        o_motor_run <= 1'b1;
                    end
                end
                T_RUN: begin
                    if (halt) begin
                        tstate_q    <= T_SUSP;
                        o_motor_run <= 1'b0;
                    end else if (sec_tick) begin
                        if (sec_cnt_q == MIN_LAST) begin
                            sec_cnt_q   <= 6'h00;
                            o_run_timer <= o_run_timer - 14'h0001;
                            if (o_run_timer == 14'h0001) begin
                                tstate_q    <= T_DONE;
                                o_motor_run <= 1'b0;
                            end
                        end else begin
                            sec_cnt_q <= sec_cnt_q + 6'h01;
                        end
                    end
                end
                T_SUSP: begin
                    // held value kept; two-wire restarts on held run level
                    if (start_cmd && !halt) begin
                        tstate_q    <= T_RUN;
                        o_motor_run <= 1'b1;
                    end
                end
                T_DONE: begin
                    o_motor_run <= 1'b0;
                    if (i_sched_mode ? !start_lvl : stop_cmd) begin
                        tstate_q    <= T_IDLE;
                        o_run_timer <= o_timer_preset;
                    end
                end
                default: begin
                    tstate_q    <= T_IDLE;
                    o_motor_run <= 1'b0;
                end
            endcase
        end
    end
endmodule // ptpl_top

// ---- rtl/ptpl_defines.vh ----
// constants for the process timer and parameter lock block
// assumes a 100 MHz system clock; included by bare name
`ifndef PTPL_DEFINES_VH
`define PTPL_DEFINES_VH

// timing
`define PTPL_CLK_NS       10
`define PTPL_SEC_NS       1000000000
`define PTPL_FLASH_MS     500
`define PTPL_UNLOCK_MIN   5
`define PTPL_MIN_SEC      60

// lock code (3552 shown for an all-zero code, 999 is the largest code)
`define PTPL_HIDE_OFFSET  15'h0DE0
`define PTPL_DEC_MOD      15'h2710
`define PTPL_CODE_MIN     14'h0000
`define PTPL_CODE_MAX     14'h03E7
`define PTPL_CODE_RST     14'h0000

// run timer preset in minutes
`define PTPL_PRESET_MIN   14'h0001
`define PTPL_PRESET_MAX   14'h270F
`define PTPL_PRESET_RST   14'h0001

// timer mode values
`define PTPL_MODE_OFF     2'h0
`define PTPL_MODE_BATCH   2'h1
`define PTPL_MODE_PERMIT  2'h2
`define PTPL_MODE_RST     2'h0

// parameter selected for a change on enter
`define PTPL_SEL_OTHER    2'h0
`define PTPL_SEL_TMODE    2'h1
`define PTPL_SEL_PRESET   2'h2

// display content codes
`define PTPL_DISP_PARAM   3'h0
`define PTPL_DISP_VALUE   3'h1
`define PTPL_DISP_END     3'h2
`define PTPL_DISP_PASS    3'h3
`define PTPL_DISP_ERR     3'h4

// control pin bit positions in the synchroniser
`define PTPL_PIN_START    0
`define PTPL_PIN_STOP     1
`define PTPL_PIN_PWR      2
`define PTPL_PIN_FAULT    3

`endif

// ---- rtl/ptpl_tick.v ----
// free running divider giving a one-cycle pulse every CYC clocks
// assumes one clock domain with synchronous active-low reset
module ptpl_tick #(
    parameter CYC = 100000000
) (
    input  wire i_clk,
    input  wire i_rst_n,
    output reg  o_tick
);
    reg [26:0] cnt_q;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_q  <= 27'h0000000;
            o_tick <= 1'b0;
        end else if (cnt_q == CYC[26:0] - 27'h0000001) begin
            cnt_q  <= 27'h0000000;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 27'h0000001;
            o_tick <= 1'b0;
        end
    end
endmodule // ptpl_tick

// ---- test/ptpl_ctl_model.sv ----
// control pin driver: start/run, stop, control power, fault trip
// assumes the bench calls its tasks from one process
module ptpl_ctl_model (
    input  wire  i_clk,
    output logic o_start,
    output logic o_stop,
    output logic o_power_ok,
    output logic o_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_start = 1'b0;
        o_stop = 1'b0;
        o_power_ok = 1'b1;
        o_fault = 1'b0;
    end
    // pin 0 start, 1 stop, 2 power, 3 fault
    task automatic drive(input int p, input logic v);
        @(posedge i_clk);
        case (p)
            0: o_start <= v;
            1: o_stop <= v;
            2: o_power_ok <= v;
            default: o_fault <= v;
        endcase
        #1;
    endtask
    // momentary press; every three-wire restart is a fresh one
    task automatic pulse(input int p);
        drive(p, 1'b1);
        repeat (3) @(posedge i_clk);
        drive(p, 1'b0);
    endtask
endmodule // ptpl_ctl_model

// ---- test/ptpl_chk.sv ----
// port-level checks of the process timer and parameter lock
// assumes one clock, synchronous active-low reset; bound after module
module ptpl_chk (
    input logic        i_clk,
    input logic        i_rst_n,
    input logic        i_lock_open,
    input logic        i_key_arrow,
    input logic        i_key_enter,
    input logic [1:0]  i_param_sel,
    input logic        o_motor_run,
    input logic [13:0] o_run_timer,
    input logic [1:0]  o_timer_mode,
    input logic [13:0] o_timer_preset,
    input logic        o_lock_enabled,
    input logic        o_unlocked,
    input logic [2:0]  o_disp_mode,
    input logic [13:0] o_disp_value,
    input logic        o_param_accept
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_open;
        o_disp_mode == 3'h0 && i_lock_open;
    endsequence
    property p_hide_empty;
        !o_lock_enabled ##0 s_open |=> o_disp_mode == 3'h1 && o_disp_value == 14'h0DE0;
    endproperty
    a_hide_empty: assert property (p_hide_empty) else $error("empty code not shown hidden");
    property p_first_arrow;
        s_open ##1 (!i_key_arrow && !i_key_enter) ##1 i_key_arrow |=> o_disp_value == 14'h0000;
    endproperty
    a_first_arrow: assert property (p_first_arrow) else $error("first arrow not zero");
    property p_hide_set;
        o_lock_enabled ##0 s_open |=> o_disp_value != 14'h0DE0;
    endproperty
    a_hide_set: assert property (p_hide_set) else $error("stored code shown as empty");
    property p_flash_end;
        $rose(o_disp_mode == 3'h2) |-> (o_disp_mode == 3'h2)[*4];
    endproperty
    a_flash_end: assert property (p_flash_end) else $error("end flash too short");
    property p_mode_rng;
        o_timer_mode <= 2'h2;
    endproperty
    a_mode_rng: assert property (p_mode_rng) else $error("timer mode out of range");
    property p_preset_rng;
        o_timer_preset >= 14'h0001 && o_timer_preset <= 14'h270F;
    endproperty
    a_preset_rng: assert property (p_preset_rng) else $error("preset out of range");
    property p_expired_off;
        o_timer_mode == 2'h1 && o_run_timer == 14'h0000 |-> !o_motor_run;
    endproperty
    a_expired_off: assert property (p_expired_off) else $error("motor on at zero");
    property p_freeze;
        o_timer_mode == 2'h1 && !o_motor_run ##1 o_timer_mode == 2'h1 && $stable(o_timer_preset)
            |-> o_run_timer == $past(o_run_timer) || $past(o_run_timer) == 14'h0000;
    endproperty
    a_freeze: assert property (p_freeze) else $error("stopped timer moved");
    property p_step;
        o_run_timer != $past(o_run_timer) && $past(o_run_timer) != 14'h0000
            && $stable(o_timer_preset) && $stable(o_timer_mode)
            && $past(o_timer_preset) == $past(o_timer_preset, 2)
            && $past(o_timer_mode) == $past(o_timer_mode, 2)
            |-> $past(o_motor_run) && o_run_timer == $past(o_run_timer) - 14'h0001;
    endproperty
    a_step: assert property (p_step) else $error("bad timer step");
    property p_locked_enter;
        o_lock_enabled && !o_unlocked && o_disp_mode == 3'h0 && i_key_enter
            && i_param_sel != 2'h0 |=> o_disp_mode == 3'h4 && !o_param_accept;
    endproperty
    a_locked_enter: assert property (p_locked_enter) else $error("locked change taken");
endmodule // ptpl_chk
bind ptpl_top ptpl_chk i_chk (.i_clk, .i_rst_n, .i_lock_open, .i_key_arrow, .i_key_enter,
    .i_param_sel, .o_motor_run, .o_run_timer, .o_timer_mode, .o_timer_preset,
    .o_lock_enabled, .o_unlocked, .o_disp_mode, .o_disp_value, .o_param_accept);

// ---- test/tb_ptpl_top.sv ----
// self-checking bench of the process timer and parameter lock
// assumes ptpl_top, the control pin model and the checker are compiled
module tb_ptpl_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_key_any = 1'b0, i_key_arrow = 1'b0;
    logic i_key_enter = 1'b0, i_lock_open = 1'b0, i_factory_restore = 1'b0;
    logic i_two_wire = 1'b0, i_sched_mode = 1'b0;
    logic [13:0] i_entry_value = 14'h0000;
    logic [1:0]  i_param_sel = 2'h0;
    wire i_start, i_stop, i_power_ok, i_fault;
    wire o_motor_run, o_lock_enabled, o_unlocked, o_param_accept;
    wire [13:0] o_run_timer, o_timer_preset, o_disp_value;
    wire [1:0]  o_timer_mode;
    wire [2:0]  o_disp_mode;
    int fails = 0;
    int check_count = 0;
    ptpl_top #(.SEC_CYC(2), .FLASH_CYC(4)) i_dut (.i_clk, .i_rst_n, .i_key_any,
        .i_key_arrow, .i_key_enter, .i_lock_open, .i_entry_value, .i_param_sel,
        .i_factory_restore, .i_two_wire, .i_sched_mode, .i_start, .i_stop, .i_power_ok,
        .i_fault, .o_motor_run, .o_run_timer, .o_timer_mode, .o_timer_preset,
        .o_lock_enabled, .o_unlocked, .o_disp_mode, .o_disp_value, .o_param_accept);
    ptpl_ctl_model i_ctl (.i_clk, .o_start(i_start), .o_stop(i_stop),
        .o_power_ok(i_power_ok), .o_fault(i_fault));
    always #5 i_clk = ~i_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // keypad pulse: 0 arrow, 1 enter, 2 open lock parameter, 3 restore
    task automatic key(input int k, input logic [13:0] v, input logic [1:0] s);
        @(posedge i_clk);
        i_entry_value <= v;
        i_param_sel <= s;
        i_key_any <= 1'b1;
        i_key_arrow <= (k == 0);
        i_key_enter <= (k == 1);
        i_lock_open <= (k == 2);
        i_factory_restore <= (k == 3);
        @(posedge i_clk);
        {i_key_any, i_key_arrow, i_key_enter, i_lock_open, i_factory_restore} <= 5'h00;
        #1;
    endtask
    function automatic logic [15:0] probe(input int w);
        case (w)
            0: return {2'h0, o_run_timer};
            1: return {15'h0000, o_motor_run};
            2: return {15'h0000, o_unlocked};
            default: return {13'h0000, o_disp_mode};
        endcase
    endfunction
    // 0 timer, 1 motor, 2 unlocked, 3 display; bounded
    task automatic wait_for(input int w, input logic [15:0] v, input int lim);
        int n;
        for (n = 0; n < lim && probe(w) !== v; n++) begin
            @(posedge i_clk);
            #1;
        end
        chk(probe(w), v);
        if (probe(w) !== v) tally_and_finish();
    endtask
    task automatic enter_code(input logic [13:0] c, input logic [2:0] m);
        key(2, 14'h0000, 2'h0);
        key(0, 14'h0000, 2'h0);
        key(1, c, 2'h0);
        chk(o_disp_mode, m);
        wait_for(3, 16'h0000, 10);
    endtask
    task automatic t_new_code();
        chk(o_timer_mode, 2'h0);
        chk(o_timer_preset, 14'h0001);
        key(2, 14'h0000, 2'h0);
        chk(o_disp_value, 14'h0DE0);
        key(0, 14'h0000, 2'h0);
        chk(o_disp_value, 14'h0000);
        key(1, 14'h03E8, 2'h0);
        chk(o_disp_mode, 3'h4);
        wait_for(3, 16'h0000, 10);
        chk(o_lock_enabled, 1'b0);
        enter_code(14'h03E7, 3'h2);
        chk(o_lock_enabled, 1'b1);
    endtask
    task automatic t_locked();
        key(1, 14'h0001, 2'h1);
        chk(o_disp_mode, 3'h4);
        wait_for(3, 16'h0000, 10);
        chk(o_timer_mode, 2'h0);
        key(2, 14'h0000, 2'h0);
        chk(o_disp_value, 14'h11C7);
        key(0, 14'h0000, 2'h0);
        key(1, 14'h03E6, 2'h0);
        chk(o_disp_mode, 3'h4);
        wait_for(3, 16'h0000, 10);
        enter_code(14'h03E7, 3'h3);
        key(1, 14'h0003, 2'h1);
        chk(o_timer_mode, 2'h0);
        wait_for(3, 16'h0000, 10);
        key(1, 14'h2710, 2'h2);
        chk(o_timer_preset, 14'h0001);
        wait_for(3, 16'h0000, 10);
        key(1, 14'h0002, 2'h2);
        chk(o_timer_preset, 14'h0002);
        wait_for(3, 16'h0000, 10);
        key(1, 14'h0001, 2'h1);
        chk(o_timer_mode, 2'h1);
        repeat (500) @(posedge i_clk);
        #1;
        chk(o_unlocked, 1'b1);
        key(0, 14'h0000, 2'h0);
        repeat (300) @(posedge i_clk);
        #1;
        chk(o_unlocked, 1'b1);
        wait_for(2, 16'h0000, 350);
    endtask
    task automatic t_three_wire();
        i_ctl.pulse(0);
        wait_for(1, 16'h0001, 10);
        chk(o_run_timer, 14'h0002);
        wait_for(0, 16'h0001, 200);
        i_ctl.pulse(1);
        wait_for(1, 16'h0000, 10);
        repeat (200) @(posedge i_clk);
        #1;
        chk(o_run_timer, 14'h0001);
        i_ctl.pulse(0);
        wait_for(1, 16'h0001, 10);
        wait_for(0, 16'h0000, 200);
        chk(o_motor_run, 1'b0);
        i_ctl.pulse(1);
        wait_for(0, 16'h0002, 10);
    endtask
    task automatic t_two_wire();
        @(posedge i_clk);
        i_two_wire <= 1'b1;
        i_ctl.drive(0, 1'b1);
        wait_for(1, 16'h0001, 12);
        i_ctl.drive(2, 1'b0);
        wait_for(1, 16'h0000, 12);
        i_ctl.drive(2, 1'b1);
        wait_for(1, 16'h0001, 12);
        i_ctl.drive(3, 1'b1);
        wait_for(1, 16'h0000, 12);
        i_ctl.drive(3, 1'b0);
        wait_for(1, 16'h0001, 12);
        wait_for(0, 16'h0000, 300);
        repeat (20) @(posedge i_clk);
        #1;
        chk(o_motor_run, 1'b0);
        i_ctl.drive(0, 1'b0);
        wait_for(0, 16'h0002, 12);
    endtask
    task automatic t_sched();
        @(posedge i_clk);
        i_two_wire <= 1'b0;
        i_sched_mode <= 1'b1;
        i_ctl.pulse(0);
        wait_for(1, 16'h0001, 10);
        wait_for(0, 16'h0000, 300);
        wait_for(0, 16'h0002, 4);
        chk(o_motor_run, 1'b0);
        @(posedge i_clk);
        i_sched_mode <= 1'b0;
    endtask
    task automatic t_restore();
        enter_code(14'h03E7, 3'h3);
        key(3, 14'h0000, 2'h0);
        chk(o_timer_mode, 2'h0);
        chk(o_timer_preset, 14'h0001);
        chk(o_lock_enabled, 1'b1);
        key(2, 14'h0000, 2'h0);
        chk(o_disp_value, 14'h11C7);
        key(1, 14'h0000, 2'h0);
        chk(o_disp_mode, 3'h0);
        enter_code(14'h0000, 3'h2);
        chk(o_lock_enabled, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_new_code();
        t_locked();
        t_three_wire();
        t_two_wire();
        t_sched();
        t_restore();
        tally_and_finish();
    end
endmodule // tb_ptpl_top
